// ===== hdl/bridge_diag_pkg.sv
// constants shared by the bridge diagnostic and control register block
package bridge_diag_pkg;
   // register byte offsets
   localparam logic [7:0] BRCTL_OFFSET      = 8'h3C;
   localparam logic [7:0] DIAG_OFFSET       = 8'h40;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h80;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h84;
   // bridge control upper field positions
   localparam int BRCTL_PRI_TO_BIT    = 24;
   localparam int BRCTL_SEC_TO_BIT    = 25;
   localparam int BRCTL_TO_STATUS_BIT = 26;
   localparam int BRCTL_DISC_SERR_BIT = 27;
   localparam logic [3:0] BRCTL_RESET = 4'h0;
   // diagnostic / chip control field positions
   localparam int DIAG_WR_DISC_BIT  = 1;
   localparam int DIAG_PREF_DIS_BIT = 4;
   localparam int DIAG_LIVE_BIT     = 5;
   localparam int DIAG_CHIP_RST_BIT = 8;
   localparam int DIAG_TEST_LSB     = 9;
   localparam logic [15:0] DIAG_RESET = 16'h0000;
   // interrupt status / mask bit positions
   localparam int IRQ_PRI_TO_BIT   = 0;
   localparam int IRQ_SEC_TO_BIT   = 1;
   localparam int IRQ_DISCARD_BIT  = 2;
   localparam int IRQ_RST_DONE_BIT = 3;
   localparam int IRQ_W            = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   // repeat wait limits as powers of two
   localparam int LONG_WAIT_EXP  = 15;
   localparam int SHORT_WAIT_EXP = 10;
   // timing
   localparam int CLK_PERIOD_NS   = 40;
   localparam int CHIP_RESET_NS   = 1000;
   localparam int CHIP_RESET_CLKS = (CHIP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// ===== hdl/repeat_timer_if.sv
// handshake between the control block and one delayed-request repeat timer
`timescale 1ns/1ps
interface repeat_timer_if;
   logic head_start;
   logic retried;
   logic short_limit;
   logic expired;
   modport timer (input head_start, input retried, input short_limit, output expired);
   modport ctrl  (output head_start, output retried, output short_limit, input expired);
endinterface

// ===== hdl/repeat_timer.sv
// repeat wait counter for the delayed transaction at the head of one queue
`timescale 1ns/1ps
module repeat_timer
   import bridge_diag_pkg::*;
#(
   parameter int LONG_CLKS  = 32768,
   parameter int SHORT_CLKS = 1024
) (
   input wire logic     hclk,
   input wire logic     hresetn,
   repeat_timer_if.timer t
);
   logic [15:0] count;
   logic        active;
   logic [15:0] limit_m1;
   logic        hit;

   assign limit_m1 = t.short_limit ? 16'(SHORT_CLKS - 1) : 16'(LONG_CLKS - 1);
   assign hit      = active && !t.retried && !t.head_start && (count == limit_m1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active <= 1'b0;
         count  <= 16'h0000;
      end else if (t.head_start) begin
         active <= 1'b1; // R2
         count  <= 16'h0000;
      end else if (t.retried || hit) begin
         active <= 1'b0;
      end else if (active) begin
         count <= count + 16'h0001;
      end
   end

   // one retry before the limit saves the entry; otherwise it is dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t.expired <= 1'b0;
      end else begin
         t.expired <= hit; // R3
      end
   end

   no_early_expire_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      t.head_start |=> !t.expired [*8])
      else $error("repeat timer expired too soon after start");
   retry_saves_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
      (t.retried && !t.head_start) |=> ##1 !t.expired)
      else $error("expiry after a retry");
endmodule

// ===== hdl/chip_reset_seq.sv
// soft chip reset sequencer, holds the reset for a fixed time then reports done
`timescale 1ns/1ps
module chip_reset_seq
   import bridge_diag_pkg::*;
(
   input wire logic  hclk,
   input wire logic  hresetn,
   input wire logic  start,
   output logic      busy,
   output logic      done
);
   logic [7:0] count;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy  <= 1'b0;
         done  <= 1'b0;
         count <= 8'h00;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy  <= 1'b1;
            count <= 8'h00;
         end else if (busy) begin
            if (count == 8'(CHIP_RESET_CLKS - 1)) begin
               busy <= 1'b0; // R15
               done <= 1'b1;
            end else begin
               count <= count + 8'h01;
            end
         end
      end
   end

   reset_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
      $rose(busy) |-> busy [*8])
      else $error("chip reset released too early");
   self_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
      done |-> $fell(busy))
      else $error("done without busy falling");
endmodule

// ===== hdl/bridge_diag_control_regs.sv
// bridge control upper fields and diagnostic/chip control register over AHB-Lite
// What this block does
// R1: secondary timeout select picks 2^15 (0) or 2^10 (1) clocks; resets 0.
// R2: repeat counter starts when a delayed transaction reaches its queue head.
// R3: no retry before expiry drops the transaction; masters must retry in time.
// R4: either counter expiring sets timeout status; write one clears; resets 0.
// R5: discard timer expiry with enable set asserts primary system error.
// R6: reserved bits read zero and ignore writes.
// R7: memory writes disconnect at 4KB boundary (0) or cache line (1).
// R8: prefetch disable 0: upstream reads prefetch, byte enables not forwarded.
// R9: prefetch disable 1: one dword per read, byte enables forwarded.
// R10: live insertion with pin 3 as input masks I/O, memory, master enables.
// R11: while masked the bridge accepts no I/O or memory transactions.
// R12: writing one to chip reset performs full chip and secondary reset.
// R13: counter test field selects all bits or byte 1, 2, 3.
// R14: primary timeout select picks 2^15 (0) or 2^10 (1) clocks.
// R15: chip reset bit clears itself when the reset sequence ends.
// R16: timeout status stays set until software clears it.
`timescale 1ns/1ps
module bridge_diag_control_regs
   import bridge_diag_pkg::*;
#(
   parameter int LONG_WAIT_CLKS  = 32768,
   parameter int SHORT_WAIT_CLKS = 1024
) (
   input wire logic         hclk,
   input wire logic         hresetn,
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic [2:0]   hsize,
   input wire logic [31:0]  hwdata,
   input wire logic         hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input wire logic         pri_head_start,
   input wire logic         pri_retried,
   input wire logic         sec_head_start,
   input wire logic         sec_retried,
   output logic             pri_discard,
   output logic             sec_discard,
   input wire logic         pri_discard_timer_expired,
   input wire logic         sec_discard_timer_expired,
   output logic             primary_system_error_n,
   output logic             primary_system_error_oe,
   input wire logic         gpio3_pin,
   input wire logic         gpio3_is_input,
   input wire logic         io_enable_cfg,
   input wire logic         mem_enable_cfg,
   input wire logic         master_enable_cfg,
   output logic             io_enable,
   output logic             mem_enable,
   output logic             master_enable,
   output logic             accept_io_mem,
   input wire logic [11:2]  target_write_addr,
   input wire logic [7:0]   cache_line_dwords,
   output logic             write_disconnect_here,
   output logic             upstream_prefetch_en,
   output logic             forward_read_be,
   output logic             chip_reset_active,
   output logic             counter_test_mode_all,
   output logic [1:0]       counter_test_mode,
   output logic             irq
);
   // control fields
   logic             pri_to_short;
   logic             sec_to_short;
   logic             to_status;
   logic             disc_serr_en;
   logic             wr_disc_cacheline;
   logic             prefetch_dis;
   logic             live_mode;
   logic [1:0]       test_mode;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic             serr_active;

   // bus state
   logic             wr_pending;
   logic             rd_wait;
   logic [7:0]       bus_addr;
   logic             accept;
   logic             wr_en;
   logic             rst_start;
   logic             rst_busy;
   logic             rst_done;

   // synchroniser for the live insertion pin
   logic             gpio3_meta;
   logic             gpio3_sync;
   logic             cmd_masked;

   repeat_timer_if pri_t ();
   repeat_timer_if sec_t ();

   assign pri_t.head_start  = pri_head_start;
   assign pri_t.retried     = pri_retried;
   assign pri_t.short_limit = pri_to_short; // R14
   assign sec_t.head_start  = sec_head_start;
   assign sec_t.retried     = sec_retried;
   assign sec_t.short_limit = sec_to_short; // R1

   repeat_timer #(
      .LONG_CLKS  (LONG_WAIT_CLKS),
      .SHORT_CLKS (SHORT_WAIT_CLKS)
   ) pri_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .t       (pri_t)
   );

   repeat_timer #(
      .LONG_CLKS  (LONG_WAIT_CLKS),
      .SHORT_CLKS (SHORT_WAIT_CLKS)
   ) sec_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .t       (sec_t)
   );

   assign pri_discard = pri_t.expired; // R3
   assign sec_discard = sec_t.expired; // R3

   chip_reset_seq rst_seq (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (rst_start),
      .busy    (rst_busy),
      .done    (rst_done)
   );

   // ---------------- AHB-Lite slave ----------------
   // writes complete with no wait; reads take one wait so a write just before
   // is already visible to the read
   assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wr_en     = wr_pending;
   assign hreadyout = !rd_wait;
   assign hresp     = HRESP_OKAY;
   assign rst_start = wr_en && (bus_addr == DIAG_OFFSET) && hwdata[DIAG_CHIP_RST_BIT]; // R12

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         rd_wait    <= 1'b0;
         bus_addr   <= 8'h00;
      end else begin
         wr_pending <= accept && hwrite;
         rd_wait    <= accept && !hwrite;
         if (accept) begin
            bus_addr <= {haddr[7:2], 2'h0};
         end
      end
   end

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000; // R6
      unique case (a)
         BRCTL_OFFSET: begin
            w[BRCTL_PRI_TO_BIT]    = pri_to_short;
            w[BRCTL_SEC_TO_BIT]    = sec_to_short;
            w[BRCTL_TO_STATUS_BIT] = to_status;
            w[BRCTL_DISC_SERR_BIT] = disc_serr_en;
         end
         DIAG_OFFSET: begin
            w[DIAG_WR_DISC_BIT]                 = wr_disc_cacheline;
            w[DIAG_PREF_DIS_BIT]                = prefetch_dis;
            w[DIAG_LIVE_BIT]                    = live_mode;
            w[DIAG_CHIP_RST_BIT]                = rst_busy; // R15
            w[DIAG_TEST_LSB+1:DIAG_TEST_LSB]    = test_mode;
         end
         IRQ_STATUS_OFFSET: w[IRQ_W-1:0] = irq_status;
         IRQ_MASK_OFFSET:   w[IRQ_W-1:0] = irq_mask;
         default:           w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_wait) begin
         hrdata <= read_word(bus_addr);
      end
   end

   // ---------------- control fields ----------------
   // a soft chip reset returns the control fields, but not the timeout status, to their reset values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {disc_serr_en, sec_to_short, pri_to_short} <= BRCTL_RESET[2:0];
      end else if (rst_start) begin
         {disc_serr_en, sec_to_short, pri_to_short} <= BRCTL_RESET[2:0];
      end else if (wr_en && bus_addr == BRCTL_OFFSET) begin
         pri_to_short <= hwdata[BRCTL_PRI_TO_BIT];    // R14
         sec_to_short <= hwdata[BRCTL_SEC_TO_BIT];    // R1
         disc_serr_en <= hwdata[BRCTL_DISC_SERR_BIT]; // R5
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_disc_cacheline <= DIAG_RESET[DIAG_WR_DISC_BIT];
         prefetch_dis      <= DIAG_RESET[DIAG_PREF_DIS_BIT];
         live_mode         <= DIAG_RESET[DIAG_LIVE_BIT];
         test_mode         <= DIAG_RESET[DIAG_TEST_LSB+1:DIAG_TEST_LSB];
      end else if (rst_start) begin
         wr_disc_cacheline <= DIAG_RESET[DIAG_WR_DISC_BIT];
         prefetch_dis      <= DIAG_RESET[DIAG_PREF_DIS_BIT];
         live_mode         <= DIAG_RESET[DIAG_LIVE_BIT];
         test_mode         <= DIAG_RESET[DIAG_TEST_LSB+1:DIAG_TEST_LSB];
      end else if (wr_en && bus_addr == DIAG_OFFSET) begin
         wr_disc_cacheline <= hwdata[DIAG_WR_DISC_BIT];
         prefetch_dis      <= hwdata[DIAG_PREF_DIS_BIT];
         live_mode         <= hwdata[DIAG_LIVE_BIT];
         test_mode         <= hwdata[DIAG_TEST_LSB+1:DIAG_TEST_LSB]; // R13
      end
   end

   // status flag: a new expiry wins over a clearing write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         to_status <= 1'b0;
      end else if (pri_t.expired || sec_t.expired) begin
         to_status <= 1'b1; // R4
      end else if (wr_en && bus_addr == BRCTL_OFFSET && hwdata[BRCTL_TO_STATUS_BIT]) begin
         to_status <= 1'b0; // R16
      end
   end

   // ---------------- interrupts ----------------
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clear;

   assign irq_events[IRQ_PRI_TO_BIT]   = pri_t.expired;
   assign irq_events[IRQ_SEC_TO_BIT]   = sec_t.expired;
   assign irq_events[IRQ_DISCARD_BIT]  = pri_discard_timer_expired || sec_discard_timer_expired;
   assign irq_events[IRQ_RST_DONE_BIT] = rst_done;
   assign irq_clear = (wr_en && bus_addr == IRQ_STATUS_OFFSET) ? hwdata[IRQ_W-1:0] : IRQ_RESET;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_en && bus_addr == IRQ_MASK_OFFSET) begin
         irq_mask <= hwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ---------------- system error ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serr_active <= 1'b0;
      end else begin
         serr_active <= disc_serr_en &&
                        (pri_discard_timer_expired || sec_discard_timer_expired); // R5
      end
   end

   // open drain: only ever pulled low
   assign primary_system_error_n  = !serr_active;
   assign primary_system_error_oe = serr_active;

   // ---------------- live insertion ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio3_meta <= 1'b0;
         gpio3_sync <= 1'b0;
      end else begin
         gpio3_meta <= gpio3_pin;
         gpio3_sync <= gpio3_meta;
      end
   end

   assign cmd_masked    = live_mode && gpio3_is_input && gpio3_sync; // R10
   assign io_enable     = io_enable_cfg && !cmd_masked;     // R10
   assign mem_enable    = mem_enable_cfg && !cmd_masked;    // R10
   assign master_enable = master_enable_cfg && !cmd_masked; // R10
   assign accept_io_mem = (io_enable || mem_enable) && !cmd_masked && !rst_busy; // R11

   // ---------------- write disconnect boundary ----------------
   // a cache line size of zero gives a mask of all ones, i.e. 256 dwords
   logic [9:0] next_dword;
   logic [9:0] line_mask;

   assign next_dword = target_write_addr + 10'h001;
   assign line_mask  = {2'h0, cache_line_dwords - 8'h01};
   assign write_disconnect_here = wr_disc_cacheline ? ((next_dword & line_mask) == 10'h000)
                                                    : (next_dword == 10'h000); // R7

   // ---------------- prefetch, reset, test ----------------
   assign upstream_prefetch_en  = !prefetch_dis; // R8
   assign forward_read_be       = prefetch_dis;  // R9
   assign chip_reset_active     = rst_busy;      // R12
   assign counter_test_mode     = test_mode;     // R13
   assign counter_test_mode_all = (test_mode == 2'h0);

   // ---------------- checks ----------------
   serr_follows_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      (disc_serr_en && (pri_discard_timer_expired || sec_discard_timer_expired))
      |=> (!primary_system_error_n && primary_system_error_oe))
      else $error("system error not raised on discard expiry");
   serr_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      !disc_serr_en |=> primary_system_error_n)
      else $error("system error raised while disabled");
   // a clearing write in the cycle right after the set may legally drop it again
   status_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      (pri_t.expired || sec_t.expired)
      |=> to_status ##1 (to_status || $past(wr_en && bus_addr == BRCTL_OFFSET)))
      else $error("timeout status not set");
   status_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
      (to_status && !(wr_en && bus_addr == BRCTL_OFFSET)) |=> to_status)
      else $error("timeout status dropped without a clear");
   live_mask_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
      (live_mode && gpio3_is_input && $past(gpio3_pin, 2) && $past(gpio3_pin, 3) &&
       !$past(rst_start) && $past(hresetn, 2))
      |-> (!io_enable && !mem_enable && !master_enable && !accept_io_mem))
      else $error("command enables not masked");
   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   diag_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
      (rd_wait && bus_addr == DIAG_OFFSET)
      |=> (hrdata[31:11] == 21'h0 && hrdata[7:6] == 2'h0 && hrdata[3:2] == 2'h0 &&
           hrdata[0] == 1'b0))
      else $error("reserved diagnostic bits not zero");
   prefetch_mode_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      (wr_en && bus_addr == DIAG_OFFSET && !rst_start)
      |=> (forward_read_be == $past(hwdata[DIAG_PREF_DIS_BIT]) &&
           upstream_prefetch_en != forward_read_be))
      else $error("prefetch mode not taken from write");

   timeout_seen_c:  cover property (@(posedge hclk) disable iff (!hresetn) sec_t.expired);
   chip_reset_c:    cover property (@(posedge hclk) disable iff (!hresetn) rst_done);
   serr_c:          cover property (@(posedge hclk) disable iff (!hresetn) serr_active);
   masked_c:        cover property (@(posedge hclk) disable iff (!hresetn) cmd_masked);
endmodule

// ===== dv/queue_head_model.sv
// delayed-request queue stub: announces a new head, optionally retries later
`timescale 1ns/1ps
module queue_head_model (
   input wire logic        hclk,
   input wire logic        start,
   input wire logic [15:0] retry_after,
   output logic            head_start,
   output logic            retried
);
   logic [15:0] cnt;
   initial begin
      head_start = 1'b0;
      retried = 1'b0;
      cnt = 16'h0000;
   end
   always @(posedge hclk) begin
      head_start <= start;
      retried <= (cnt == 16'h0001);
      if (start) begin
         cnt <= retry_after;
      end else if (cnt != 16'h0000) begin
         cnt <= cnt - 16'h0001;
      end
   end
endmodule

// ===== dv/bridge_diag_control_regs_test.sv
// self-checking bench for the bridge control and diagnostic registers
`timescale 1ns/1ps
module bridge_diag_control_regs_test;
   import bridge_diag_pkg::*;
   // short wait limits keep the run brief
   localparam int LONG_T  = 64;
   localparam int SHORT_T = 16;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0]  htrans, tm;
   logic        pri_start, sec_start, pri_hs, pri_rt, sec_hs, sec_rt;
   logic [15:0] pri_ra, sec_ra;
   logic        pri_disc, sec_disc, pri_dte, sec_dte, serr_n, serr_oe;
   logic        gpin, gin, io_c, mem_c, mst_c, io_en, mem_en, mst_en, acc;
   logic [11:2] twa;
   logic [7:0]  cld;
   logic        wdh, pf_en, fwd_be, cra, tm_all, irq;
   int          fails, total_checks;

   queue_head_model pri_q (.hclk(hclk), .start(pri_start), .retry_after(pri_ra),
      .head_start(pri_hs), .retried(pri_rt));
   queue_head_model sec_q (.hclk(hclk), .start(sec_start), .retry_after(sec_ra),
      .head_start(sec_hs), .retried(sec_rt));

   bridge_diag_control_regs #(.LONG_WAIT_CLKS(LONG_T), .SHORT_WAIT_CLKS(SHORT_T)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pri_head_start(pri_hs), .pri_retried(pri_rt), .sec_head_start(sec_hs),
      .sec_retried(sec_rt), .pri_discard(pri_disc), .sec_discard(sec_disc),
      .pri_discard_timer_expired(pri_dte), .sec_discard_timer_expired(sec_dte),
      .primary_system_error_n(serr_n), .primary_system_error_oe(serr_oe),
      .gpio3_pin(gpin), .gpio3_is_input(gin), .io_enable_cfg(io_c),
      .mem_enable_cfg(mem_c), .master_enable_cfg(mst_c), .io_enable(io_en),
      .mem_enable(mem_en), .master_enable(mst_en), .accept_io_mem(acc),
      .target_write_addr(twa), .cache_line_dwords(cld), .write_disconnect_here(wdh),
      .upstream_prefetch_en(pf_en), .forward_read_be(fwd_be), .chip_reset_active(cra),
      .counter_test_mode_all(tm_all), .counter_test_mode(tm), .irq(irq));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task wt;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   task aph(input logic [7:0] a, input logic w);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wt();
      htrans <= 2'h0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      aph(a, 1'b1);
      hwdata <= d;
      wt();
      @(negedge hclk);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      aph(a, 1'b0);
      wt();
      chk(hrdata, e);
   endtask
   // starts one delayed request; counts edges from head until discard
   task tmr(input logic sec, input logic [15:0] ra, input logic [31:0] e);
      int n;
      @(posedge hclk);
      sec_start <= sec;
      pri_start <= !sec;
      sec_ra <= ra;
      pri_ra <= ra;
      @(posedge hclk);
      sec_start <= 1'b0;
      pri_start <= 1'b0;
      while ((sec ? sec_hs : pri_hs) !== 1'b1) @(posedge hclk);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while ((sec ? sec_disc : pri_disc) !== 1'b1 && n < 2 * LONG_T);
      chk(32'(n), e);
      @(negedge hclk);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge hclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {pri_start, sec_start, pri_ra, sec_ra, pri_dte, sec_dte, gpin, gin} = '0;
      {io_c, mem_c, mst_c} = 3'h7;
      twa = 10'h3FF;
      cld = 8'h08;
      fails = 0;
      total_checks = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      rd_chk(BRCTL_OFFSET, 32'h0);
      rd_chk(DIAG_OFFSET, 32'h0);
      chkb(pf_en, 1'b1);
      chkb(wdh, 1'b1);
      wr(BRCTL_OFFSET, 32'hFFFFFFFF);
      rd_chk(BRCTL_OFFSET, 32'h0B000000);
      wr(DIAG_OFFSET, 32'hFFFFFEFF);
      rd_chk(DIAG_OFFSET, 32'h00000632);
      chkb(fwd_be, 1'b1);
      chkb(pf_en, 1'b0);
      rd_chk(8'h10, 32'h0);
      for (int m = 0; m < 4; m++) begin
         wr(DIAG_OFFSET, {21'h0, m[1:0], 9'h0});
         chk({30'h0, tm}, 32'(m));
         chkb(tm_all, m == 0);
      end
      @(posedge hclk) twa <= 10'h007;
      @(negedge hclk) chkb(wdh, 1'b0);
      wr(DIAG_OFFSET, 32'h2);
      chkb(wdh, 1'b1);
      wr(DIAG_OFFSET, 32'h20);
      @(posedge hclk) {gpin, gin} <= 2'h3;
      repeat (3) @(negedge hclk);
      chk({28'h0, io_en, mem_en, mst_en, acc}, 32'h0);
      wr(DIAG_OFFSET, 32'h0);
      chk({28'h0, io_en, mem_en, mst_en, acc}, 32'hF);
      wr(BRCTL_OFFSET, 32'h08000000);
      @(posedge hclk) pri_dte <= 1'b1;
      @(posedge hclk) pri_dte <= 1'b0;
      @(negedge hclk) chk({30'h0, serr_n, serr_oe}, 32'h1);
      wr(BRCTL_OFFSET, 32'h02000000);
      @(posedge hclk) sec_dte <= 1'b1;
      @(posedge hclk) sec_dte <= 1'b0;
      repeat (2) @(posedge hclk);
      chkb(serr_n, 1'b1);
      wr(IRQ_MASK_OFFSET, 32'h0);
      tmr(1'b1, 16'h0, 32'(SHORT_T + 1));
      rd_chk(BRCTL_OFFSET, 32'h06000000);
      rd_chk(IRQ_STATUS_OFFSET, 32'h6);
      chkb(irq, 1'b0);
      wr(IRQ_MASK_OFFSET, 32'h2);
      chkb(irq, 1'b1);
      tmr(1'b0, 16'h0, 32'(LONG_T + 1));
      rd_chk(BRCTL_OFFSET, 32'h06000000);
      rd_chk(IRQ_STATUS_OFFSET, 32'h7);
      wr(BRCTL_OFFSET, 32'h04000000);
      rd_chk(BRCTL_OFFSET, 32'h0);
      wr(IRQ_STATUS_OFFSET, 32'h3);
      chkb(irq, 1'b0);
      tmr(1'b1, 16'h5, 32'(2 * LONG_T));
      rd_chk(BRCTL_OFFSET, 32'h0);
      wr(BRCTL_OFFSET, 32'h01000000);
      tmr(1'b0, 16'h0, 32'(SHORT_T + 1));
      wr(BRCTL_OFFSET, 32'h0F000000);
      wr(IRQ_STATUS_OFFSET, 32'hF);
      wr(IRQ_MASK_OFFSET, 32'h8);
      wr(DIAG_OFFSET, 32'h100);
      chkb(cra, 1'b1);
      chkb(acc, 1'b0);
      rd_chk(DIAG_OFFSET, 32'h100);
      for (int i = 0; i < 100 && cra !== 1'b0; i++) @(posedge hclk);
      rd_chk(DIAG_OFFSET, 32'h0);
      rd_chk(BRCTL_OFFSET, 32'h0);
      chkb(irq, 1'b1);
      tally_and_finish();
   end
endmodule
